// [design/boot_cmd_engine.sv]
`timescale 1ns/1ps
// Contract
// - Three boot phases: adjust, inquiry/selection, programming; start in adjust.
// - Host sends a zero byte; bit time comes from its low duration.
// - After adjustment, enter inquiry/selection and accept its commands.
// - Transition command loads erase routines, erases both arrays, then programming.
// - Programming phase runs load, sum check and blank check commands.
// - Inquiries and the acknowledge are single bytes without size or sum.
// - Long frames: code, one size byte, n data bytes, checksum.
// - All bytes from code to checksum sum to zero modulo 256; checked.
// - Failure reply is two bytes: command error code, then error type.
// - Programming frame: four address bytes plus a unit block, no size.
// - Memory read response carries a four-byte size field.
// - Inquiry phase answers the device, clock, array and unit inquiries.
// - Repeated selections: the latest one received is the one applied.
// - After transition, inquiries and selections are refused except status; the code passes them to the op handler as long frames.
// - Status inquiry answered in every phase; the code ignores it during adjust.
// - Inquiries accepted in any subset and any order.
// - Valid bit rate selection changes the serial bit time.
// - Successful selection is answered by the acknowledge byte.
// - Failed device selection: error byte, then sum or code mismatch code.
module boot_cmd_engine
  import boot_cmd_pkg::*;
#(
  parameter int          PROG_UNIT     = 128,
  parameter logic [7:0]  CMD_PROGRAM   = 8'h50,
  parameter logic [7:0]  CMD_MEM_READ  = 8'h52,
  // Arbitrary value, stands for the accepted device code
  parameter logic [31:0] DEV_CODE      = 32'h4142_4344,
  parameter logic [7:0]  NUM_CLK_MODES = 8'h02
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             op_req_o,
  output logic [7:0]       op_code_o,
  input  wire logic        op_done_i,
  input  wire logic        op_ok_i,
  input  wire logic [7:0]  op_err_i,
  input  wire logic [7:0]  op_resp_i,
  input  wire logic [31:0] op_len_i,
  input  wire logic        pay_valid_i,
  input  wire logic [7:0]  pay_data_i,
  output logic             pay_ready_o,
  output logic             fwd_valid_o,
  output logic [7:0]       fwd_data_o,
  output logic             frame_bad_o,
  output logic [1:0]       boot_state_o,
  output logic [15:0]      bit_cyc_o,
  output logic [31:0]      dev_code_o,
  output logic [7:0]       clk_mode_o
);

  boot_state_e boot_q;
  cmd_state_e  st_q;
  logic        rx_s1_q, rx_s2_q, rx_s3_q;
  logic [15:0] bit_q, rate_q, rx_cnt_q, tx_cnt_q;
  logic        rate_pend_q;
  logic [19:0] adj_cnt_q;
  logic        adj_run_q;
  logic [28:0] adj_prod;
  logic        rx_busy_q, rx_vld_q;
  logic [3:0]  rx_bit_q, tx_bit_q;
  logic [7:0]  rx_sh_q, b;
  logic [7:0]  cmd_q, size_q, cnt_q, sum_q, err_q, snd_code_q, tx_byte;
  logic [31:0] sh_q, len_q, ln_q;
  logic [1:0]  lcnt_q;
  logic        pay_int_q, sel_q;
  logic        buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, emit;
  logic [7:0]  buf_out_data;
  logic        tx_busy_q;
  logic [8:0]  tx_sh_q;

  assign b = rx_sh_q;
  assign boot_state_o = boot_q;
  assign bit_cyc_o = bit_q;
  assign adj_prod = 29'(adj_cnt_q * ADJ_MUL);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage and later are read
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot phase
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      boot_q <= ST_ADJUST;
    end else if (boot_q == ST_ADJUST && adj_run_q && rx_s2_q && !rx_s3_q
                 && adj_prod[ADJ_SHIFT+15:ADJ_SHIFT] >= MIN_BIT_CYC) begin
      boot_q <= ST_INQUIRY;
    end else if (st_q == C_OP && op_done_i && op_ok_i && cmd_q == CMD_TRANSITION
                 && boot_q == ST_INQUIRY) begin
      boot_q <= ST_PROGRAM;
    end
  end

  // Low time of the zero byte, from its falling to its rising edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      adj_cnt_q <= 20'h0;
      adj_run_q <= 1'b0;
    end else if (boot_q == ST_ADJUST) begin
      if (!rx_s2_q && rx_s3_q) begin
        adj_run_q <= 1'b1;
        adj_cnt_q <= 20'h1;
      end else if (adj_run_q && !rx_s2_q && adj_cnt_q != 20'hfffff) begin
        adj_cnt_q <= 20'(adj_cnt_q + 20'h1);
      end else if (rx_s2_q) begin
        adj_run_q <= 1'b0;
      end
    end
  end

  // Bit time; a new rate waits until the acknowledge has left the pin
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bit_q       <= RESET_BIT_CYC;
      rate_pend_q <= 1'b0;
    end else if (boot_q == ST_ADJUST && adj_run_q && rx_s2_q && !rx_s3_q
                 && adj_prod[ADJ_SHIFT+15:ADJ_SHIFT] >= MIN_BIT_CYC) begin
      bit_q <= adj_prod[ADJ_SHIFT+15:ADJ_SHIFT];
    end else if (st_q == C_SUM && rx_vld_q && sel_q && cmd_q == CMD_RATE_SEL
                 && 8'(sum_q + b) == 8'h00 && size_q == SIZE_RATE_SEL
                 && sh_q[15:0] >= MIN_BIT_CYC) begin
      rate_pend_q <= 1'b1;
      rate_q      <= sh_q[15:0];
    end else if (rate_pend_q && !tx_busy_q && !buf_out_valid && st_q == C_CODE) begin
      bit_q       <= rate_q;
      rate_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver, sampling mid-bit
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_busy_q <= 1'b0;
      rx_vld_q  <= 1'b0;
      rx_cnt_q  <= 16'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else begin
      rx_vld_q <= 1'b0;
      if (boot_q == ST_ADJUST) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= bit_q >> 1;
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0) begin
        rx_cnt_q <= 16'(rx_cnt_q - 16'h1);
      end else begin
        rx_cnt_q <= 16'(bit_q - 16'h1);
        rx_bit_q <= 4'(rx_bit_q + 4'h1);
        if (rx_bit_q == 4'h0 && rx_s2_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_vld_q  <= rx_s2_q;  // Framing error drops the byte
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command engine
  assign emit = buf_in_valid && buf_in_ready;
  assign pay_ready_o = (st_q == C_PAY) && !pay_int_q && buf_in_ready;

  always_comb begin
    case (st_q)
      C_HDR:   tx_byte = snd_code_q;
      C_LEN:   tx_byte = 8'(len_q >> {lcnt_q, 3'b000});
      C_PAY:   tx_byte = pay_int_q ? ((ln_q == STATUS_LEN) ? {6'h00, boot_q} : err_q) : pay_data_i;
      C_CSUM:  tx_byte = 8'(8'h00 - sum_q);
      C_ERR1:  tx_byte = cmd_q | ERR_RSP_FLAG;
      C_ERR2:  tx_byte = err_q;
      C_ACK:   tx_byte = RSP_ACK;
      default: tx_byte = 8'h00;
    endcase
    buf_in_valid = (st_q >= C_HDR) && (st_q != C_PAY || pay_int_q || pay_valid_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q        <= C_CODE;
      cmd_q       <= 8'h00;
      size_q      <= 8'h00;
      cnt_q       <= 8'h00;
      sum_q       <= 8'h00;
      sh_q        <= 32'h0;
      err_q       <= 8'h00;
      snd_code_q  <= 8'h00;
      len_q       <= 32'h0;
      ln_q        <= 32'h0;
      lcnt_q      <= 2'h0;
      pay_int_q   <= 1'b0;
      sel_q       <= 1'b0;
      op_req_o    <= 1'b0;
      op_code_o   <= 8'h00;
      fwd_valid_o <= 1'b0;
      fwd_data_o  <= 8'h00;
      frame_bad_o <= 1'b0;
      dev_code_o  <= 32'h0;
      clk_mode_o  <= 8'h00;
    end else begin
      op_req_o    <= 1'b0;
      fwd_valid_o <= 1'b0;
      frame_bad_o <= 1'b0;
      case (st_q)
        // Bytes that arrive while answering are dropped
        C_CODE: if (rx_vld_q && boot_q != ST_ADJUST) begin
          cmd_q <= b;
          sum_q <= b;
          cnt_q <= 8'h00;
          sh_q  <= 32'h0;
          sel_q <= 1'b0;
          pay_int_q <= 1'b0;
          if (b == CMD_STATUS) begin
            snd_code_q <= RSP_STATUS;
            len_q      <= STATUS_LEN;
            pay_int_q  <= 1'b1;
            st_q       <= C_HDR;
          end else if (boot_q == ST_PROGRAM) begin
            if (b == CMD_PROGRAM) begin
              size_q <= 8'(PROG_ADDR_LEN + PROG_UNIT);
              st_q   <= C_DATA;
            end else begin
              st_q <= C_SIZE;
            end
          end else if ((b >= CMD_INQ_FIRST && b <= CMD_INQ_LAST) || b == CMD_TRANSITION) begin
            op_req_o  <= 1'b1;
            op_code_o <= b;
            st_q      <= C_OP;
          end else if (b == CMD_DEV_SEL || b == CMD_CLK_SEL || b == CMD_RATE_SEL) begin
            sel_q <= 1'b1;
            st_q  <= C_SIZE;
          end else begin
            err_q <= ERR_COMMAND;
            st_q  <= C_ERR1;
          end
        end
        C_SIZE: if (rx_vld_q) begin
          size_q <= b;
          sum_q  <= 8'(sum_q + b);
          st_q   <= (b == 8'h00) ? C_SUM : C_DATA;
        end
        C_DATA: if (rx_vld_q) begin
          sum_q <= 8'(sum_q + b);
          sh_q  <= {sh_q[23:0], b};
          cnt_q <= 8'(cnt_q + 8'h01);
          if (boot_q == ST_PROGRAM) begin
            fwd_valid_o <= 1'b1;
            fwd_data_o  <= b;
          end
          if (8'(cnt_q + 8'h01) == size_q) st_q <= C_SUM;
        end
        C_SUM: if (rx_vld_q) begin
          if (8'(sum_q + b) != 8'h00) begin
            err_q       <= ERR_SUM;
            frame_bad_o <= 1'b1;
            st_q        <= C_ERR1;
          end else if (!sel_q) begin
            op_req_o  <= 1'b1;
            op_code_o <= cmd_q;
            st_q      <= C_OP;
          end else if (cmd_q == CMD_DEV_SEL) begin
            if (size_q == SIZE_DEV_SEL && sh_q == DEV_CODE) begin
              dev_code_o <= sh_q;
              st_q       <= C_ACK;
            end else begin
              err_q <= ERR_DEVICE;
              st_q  <= C_ERR1;
            end
          end else if (cmd_q == CMD_CLK_SEL) begin
            if (size_q == SIZE_CLK_SEL && sh_q[7:0] < NUM_CLK_MODES) begin
              clk_mode_o <= sh_q[7:0];
              st_q       <= C_ACK;
            end else begin
              err_q <= ERR_CLK_MODE;
              st_q  <= C_ERR1;
            end
          end else if (size_q == SIZE_RATE_SEL && sh_q[15:0] >= MIN_BIT_CYC) begin
            st_q <= C_ACK;
          end else begin
            err_q <= ERR_RATE;
            st_q  <= C_ERR1;
          end
        end
        C_OP: if (op_done_i) begin
          if (!op_ok_i) begin
            err_q <= op_err_i;
            st_q  <= C_ERR1;
          end else if (op_len_i == 32'h0) begin
            st_q <= C_ACK;
          end else begin
            snd_code_q <= op_resp_i;
            len_q      <= op_len_i;
            st_q       <= C_HDR;
          end
        end
        C_HDR: if (emit) begin
          sum_q  <= tx_byte;
          ln_q   <= len_q;
          lcnt_q <= (cmd_q == CMD_MEM_READ) ? LONG_SIZE_LAST : 2'h0;
          st_q   <= C_LEN;
        end
        C_LEN: if (emit) begin
          sum_q  <= 8'(sum_q + tx_byte);
          lcnt_q <= 2'(lcnt_q - 2'h1);
          if (lcnt_q == 2'h0) st_q <= (len_q == 32'h0) ? C_CSUM : C_PAY;
        end
        C_PAY: if (emit) begin
          sum_q <= 8'(sum_q + tx_byte);
          ln_q  <= 32'(ln_q - 32'h1);
          if (ln_q == 32'h1) st_q <= C_CSUM;
        end
        C_ERR1: if (emit) st_q <= C_ERR2;
        C_CSUM, C_ERR2, C_ACK: if (emit) st_q <= C_CODE;
        default: st_q <= C_CODE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit path; the buffer absorbs a byte while the shifter is busy
  boot_resp_buffer #(
    .W (8)
  ) u_buf (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (buf_in_valid),
    .in_data_i   (tx_byte),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (buf_out_valid),
    .out_data_o  (buf_out_data),
    .out_ready_i (buf_out_ready)
  );

  assign buf_out_ready = !tx_busy_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 9'h1ff;
      txd_o     <= 1'b1;
    end else if (!tx_busy_q) begin
      if (buf_out_valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, buf_out_data};
        txd_o     <= 1'b0;
        tx_cnt_q  <= 16'(bit_q - 16'h1);
        tx_bit_q  <= 4'h0;
      end
    end else if (tx_cnt_q != 16'h0) begin
      tx_cnt_q <= 16'(tx_cnt_q - 16'h1);
    end else if (tx_bit_q == 4'h9) begin
      tx_busy_q <= 1'b0;
    end else begin
      txd_o    <= tx_sh_q[0];
      tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
      tx_bit_q <= 4'(tx_bit_q + 4'h1);
      tx_cnt_q <= 16'(bit_q - 16'h1);
    end
  end

endmodule : boot_cmd_engine

// [design/boot_cmd_pkg.sv]
package boot_cmd_pkg;

  // Boot phases
  typedef enum logic [1:0] {
    ST_ADJUST,
    ST_INQUIRY,
    ST_PROGRAM
  } boot_state_e;

  // Command handling phases
  typedef enum logic [3:0] {
    C_CODE,
    C_SIZE,
    C_DATA,
    C_SUM,
    C_OP,
    C_HDR,
    C_LEN,
    C_PAY,
    C_CSUM,
    C_ERR1,
    C_ERR2,
    C_ACK
  } cmd_state_e;

  localparam logic [7:0]  CMD_DEV_SEL     = 8'h10;
  localparam logic [7:0]  CMD_CLK_SEL     = 8'h11;
  localparam logic [7:0]  CMD_RATE_SEL    = 8'h3f;
  localparam logic [7:0]  CMD_TRANSITION  = 8'h40;
  localparam logic [7:0]  CMD_STATUS      = 8'h4f;
  localparam logic [7:0]  CMD_INQ_FIRST   = 8'h20;
  localparam logic [7:0]  CMD_INQ_LAST    = 8'h27;
  localparam logic [7:0]  RSP_ACK         = 8'h06;
  localparam logic [7:0]  RSP_STATUS      = 8'h5f;
  localparam logic [7:0]  ERR_RSP_FLAG    = 8'h80;
  localparam logic [7:0]  ERR_SUM         = 8'h11;
  localparam logic [7:0]  ERR_DEVICE      = 8'h21;
  localparam logic [7:0]  ERR_CLK_MODE    = 8'h22;
  localparam logic [7:0]  ERR_RATE        = 8'h24;
  localparam logic [7:0]  ERR_COMMAND     = 8'h80;
  localparam logic [7:0]  SIZE_DEV_SEL    = 8'h04;
  localparam logic [7:0]  SIZE_CLK_SEL    = 8'h01;
  localparam logic [7:0]  SIZE_RATE_SEL   = 8'h02;
  localparam logic [7:0]  PROG_ADDR_LEN   = 8'h04;
  localparam logic [31:0] STATUS_LEN      = 32'h0000_0002;
  localparam logic [1:0]  LONG_SIZE_LAST  = 2'h3;
  // Low time of a zero byte: start bit plus eight data bits
  localparam int          ADJ_LOW_BITS    = 9;
  // Divide by nine as a multiply: 455 / 4096
  localparam logic [8:0]  ADJ_MUL         = 9'h1c7;
  localparam int          ADJ_SHIFT       = 12;
  localparam logic [15:0] MIN_BIT_CYC     = 16'h0004;
  localparam logic [15:0] RESET_BIT_CYC   = 16'h01b2;

endpackage : boot_cmd_pkg

// [design/boot_resp_buffer.sv]
`timescale 1ns/1ps
module boot_resp_buffer #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  logic [W-1:0] mem_q [0:1];
  logic         wr_ptr_q;
  logic         rd_ptr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule : boot_resp_buffer

// [tb/boot_cmd_engine_properties.sv]
`timescale 1ns/1ps
module boot_cmd_engine_checker
  import boot_cmd_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        op_req_o,
  input wire logic [7:0]  op_code_o,
  input wire logic        op_done_i,
  input wire logic        op_ok_i,
  input wire logic [7:0]  op_err_i,
  input wire logic [7:0]  op_resp_i,
  input wire logic [31:0] op_len_i,
  input wire logic        pay_valid_i,
  input wire logic [7:0]  pay_data_i,
  input wire logic        pay_ready_o,
  input wire logic        fwd_valid_o,
  input wire logic [7:0]  fwd_data_o,
  input wire logic        frame_bad_o,
  input wire logic [1:0]  boot_state_o,
  input wire logic [15:0] bit_cyc_o,
  input wire logic [31:0] dev_code_o,
  input wire logic [7:0]  clk_mode_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  property p_reset_state; disable iff (1'b0)
    reset_i |=> boot_state_o == 2'h0 && bit_cyc_o == RESET_BIT_CYC && txd_o; endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  property p_adjust_exit; boot_state_o == 2'h0 ##1 boot_state_o != 2'h0 |-> boot_state_o == 2'h1; endproperty
  a_adjust_exit: assert property (p_adjust_exit) else $error("adjust left to wrong phase");
  property p_no_return; boot_state_o != 2'h0 |=> boot_state_o != 2'h0; endproperty
  a_no_return: assert property (p_no_return) else $error("phase fell back to adjust");
  // Selections frozen once programming begins
  property p_prog_sticky;
    boot_state_o == 2'h2 |=> boot_state_o == 2'h2 && $stable(dev_code_o) && $stable(clk_mode_o); endproperty
  a_prog_sticky: assert property (p_prog_sticky) else $error("programming phase not held");
  property p_prog_entry; boot_state_o == 2'h1 ##1 boot_state_o == 2'h2 |-> op_code_o == CMD_TRANSITION; endproperty
  a_prog_entry: assert property (p_prog_entry) else $error("programming entered without transition");
  property p_silent_adjust; boot_state_o == 2'h0 |-> txd_o; endproperty
  a_silent_adjust: assert property (p_silent_adjust) else $error("transmit during adjust");
  property p_rate_floor; bit_cyc_o >= MIN_BIT_CYC; endproperty
  a_rate_floor: assert property (p_rate_floor) else $error("bit time below floor");
  // A rate change mid-byte would corrupt the reply
  property p_rate_idle; $changed(bit_cyc_o) && $past(boot_state_o) != 2'h0 |-> txd_o && $past(txd_o); endproperty
  a_rate_idle: assert property (p_rate_idle) else $error("bit time changed while sending");
  property p_bad_reply; frame_bad_o |-> ##[1:300] $fell(txd_o); endproperty
  a_bad_reply: assert property (p_bad_reply) else $error("no error reply after bad sum");
  property p_code_hold; !op_req_o |-> $stable(op_code_o); endproperty
  a_code_hold: assert property (p_code_hold) else $error("op code moved without request");
  c_prog: cover property (boot_state_o == 2'h1 ##1 boot_state_o == 2'h2);
  c_bad: cover property (frame_bad_o);
  c_op: cover property (op_req_o ##[1:20] op_done_i);
endmodule : boot_cmd_engine_checker

bind boot_cmd_engine boot_cmd_engine_checker boot_cmd_engine_checker_inst (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .rxd_i(rxd_i), .txd_o(txd_o), .op_req_o(op_req_o),
  .op_code_o(op_code_o), .op_done_i(op_done_i), .op_ok_i(op_ok_i), .op_err_i(op_err_i), .op_resp_i(op_resp_i),
  .op_len_i(op_len_i), .pay_valid_i(pay_valid_i), .pay_data_i(pay_data_i), .pay_ready_o(pay_ready_o),
  .fwd_valid_o(fwd_valid_o), .fwd_data_o(fwd_data_o), .frame_bad_o(frame_bad_o), .boot_state_o(boot_state_o),
  .bit_cyc_o(bit_cyc_o), .dev_code_o(dev_code_o), .clk_mode_o(clk_mode_o));

// [tb/boot_host_model.sv]
`timescale 1ns/1ps
module boot_host_model (
  input  wire logic core_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int         bit_cyc = 16;
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rxd_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk_i);
      rxd_o = f[i];
      repeat (bit_cyc - 1) @(negedge core_clk_i);
    end
  endtask : send_byte
  // Low time longer than nine bits keeps rounding robust
  task automatic send_zero(input int low);
    @(negedge core_clk_i);
    rxd_o = 1'b0;
    repeat (low) @(negedge core_clk_i);
    rxd_o = 1'b1;
    repeat (4 * bit_cyc) @(negedge core_clk_i);
  endtask : send_zero
  ////////////////////////////////////////////////////////////////////////
  // Samples mid-bit at the host's own rate
  always begin
    @(negedge txd_i);
    repeat (bit_cyc / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge core_clk_i);
      sh[i] = txd_i;
    end
    repeat (bit_cyc) @(posedge core_clk_i);
    rx_q.push_back(sh);
  end
endmodule : boot_host_model

// [tb/boot_serial_command_protocol_tb_top.sv]
`timescale 1ns/1ps
module boot_serial_command_protocol_tb_top;
  import boot_cmd_pkg::*;
  typedef logic [7:0] bytes_t[$];
  // Arbitrary device code
  localparam logic [31:0] DEV = 32'h4142_4344;
  localparam logic [7:0]  PROG = 8'h50;
  localparam logic [7:0]  MRD = 8'h52;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        rxd, txd, op_req, pay_ready, fwd_valid, frame_bad, taken;
  logic        op_done = 1'b0, op_ok = 1'b0, pay_valid = 1'b0, h_ok = 1'b1;
  logic [7:0]  op_code, fwd_data, clk_mode, op_err = 8'h00, op_resp = 8'h00, pay_data = 8'h00, h_err = 8'h00;
  logic [31:0] op_len = 32'h0, dev_code, h_len = 32'h0;
  logic [1:0]  boot_state;
  logic [15:0] bit_cyc, rnd = 16'hfa81;
  int          err_count = 0, cmp_count = 0, cyc = 0, bad_n = 0, fwd_n = 0;
  bytes_t      pay_q, exp;
  always #10 core_clk_i = ~core_clk_i;
  boot_cmd_engine #(.DEV_CODE(DEV), .CMD_PROGRAM(PROG), .CMD_MEM_READ(MRD)) boot_cmd_engine_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .rxd_i(rxd), .txd_o(txd), .op_req_o(op_req), .op_code_o(op_code),
    .op_done_i(op_done), .op_ok_i(op_ok), .op_err_i(op_err), .op_resp_i(op_resp), .op_len_i(op_len),
    .pay_valid_i(pay_valid), .pay_data_i(pay_data), .pay_ready_o(pay_ready), .fwd_valid_o(fwd_valid),
    .fwd_data_o(fwd_data), .frame_bad_o(frame_bad), .boot_state_o(boot_state), .bit_cyc_o(bit_cyc),
    .dev_code_o(dev_code), .clk_mode_o(clk_mode));
  boot_host_model boot_host_model_inst (.core_clk_i(core_clk_i), .txd_i(txd), .rxd_o(rxd));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic bytes_t framed(input bytes_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    q.push_back(8'h00 - s);
    return q;
  endfunction : framed
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // Host waits for the whole reply, then a quiet gap to catch extra bytes
  task automatic run_cmd(input bytes_t tx, input bytes_t ex);
    int n;
    n = 0;
    boot_host_model_inst.rx_q.delete();
    foreach (tx[i]) boot_host_model_inst.send_byte(tx[i]);
    while (boot_host_model_inst.rx_q.size() < ex.size() && n < 30000) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (12 * boot_host_model_inst.bit_cyc) @(posedge core_clk_i);
    chk("reply_len", ex.size(), boot_host_model_inst.rx_q.size());
    foreach (ex[i]) chk("reply_byte", ex[i], boot_host_model_inst.rx_q[i]);
  endtask : run_cmd
  ////////////////////////////////////////////////////////////////////////
  // Outside op handler: random latency, payload offered byte by byte
  always begin
    @(negedge core_clk_i);
    if (op_req === 1'b1) begin
      rnd = lfsr(rnd);
      repeat (1 + rnd[2:0]) @(negedge core_clk_i);
      op_done = 1'b1;
      op_ok = h_ok;
      op_err = h_err;
      op_resp = op_code + 8'h10;
      op_len = h_len;
      @(negedge core_clk_i);
      op_done = 1'b0;
      while (pay_q.size() > 0) begin
        pay_valid = 1'b1;
        pay_data = pay_q[0];
        #5;
        taken = pay_ready;
        @(negedge core_clk_i);
        if (taken === 1'b1) pay_q.delete(0);
      end
      pay_valid = 1'b0;
    end
  end
  always @(negedge core_clk_i) begin
    if (frame_bad === 1'b1) bad_n++;
    if (fwd_valid === 1'b1) fwd_n++;
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk("boot_state", 2'h0, boot_state);
    chk("bit_cyc", RESET_BIT_CYC, bit_cyc);
    chk("txd", 1'b1, txd);
    boot_host_model_inst.send_zero(149);
    chk("bit_cyc", 149 / ADJ_LOW_BITS, bit_cyc);
    chk("boot_state", 2'h1, boot_state);
    run_cmd('{8'h55}, '{8'h55 | ERR_RSP_FLAG, ERR_COMMAND});
    for (int c = 8'h27; c >= 8'h20; c--) begin
      rnd = lfsr(rnd);
      pay_q = '{rnd[7:0], rnd[15:8]};
      h_len = 32'h2;
      exp = framed('{c[7:0] + 8'h10, 8'h02, rnd[7:0], rnd[15:8]});
      run_cmd('{c[7:0]}, exp);
      chk("op_code", c, op_code);
    end
    run_cmd('{CMD_DEV_SEL, SIZE_DEV_SEL, 8'h41, 8'h42, 8'h43, 8'h44, 8'h00}, '{8'h90, ERR_SUM});
    chk("frame_bad_count", 1, bad_n);
    run_cmd(framed('{CMD_DEV_SEL, SIZE_DEV_SEL, 8'h41, 8'h42, 8'h43, 8'h45}), '{8'h90, ERR_DEVICE});
    run_cmd(framed('{CMD_DEV_SEL, SIZE_DEV_SEL, 8'h41, 8'h42, 8'h43, 8'h44}), '{RSP_ACK});
    chk("dev_code", DEV, dev_code);
    run_cmd(framed('{CMD_CLK_SEL, SIZE_CLK_SEL, 8'h01}), '{RSP_ACK});
    run_cmd(framed('{CMD_CLK_SEL, SIZE_CLK_SEL, 8'h00}), '{RSP_ACK});
    run_cmd(framed('{CMD_CLK_SEL, SIZE_CLK_SEL, 8'h02}), '{8'h91, ERR_CLK_MODE});
    chk("clk_mode", 8'h00, clk_mode);
    run_cmd(framed('{CMD_RATE_SEL, SIZE_RATE_SEL, 8'h00, 8'h03}), '{8'hbf, ERR_RATE});
    run_cmd(framed('{CMD_RATE_SEL, SIZE_RATE_SEL, 8'h00, 8'h18}), '{RSP_ACK});
    chk("bit_cyc", 16'h0018, bit_cyc);
    boot_host_model_inst.bit_cyc = 24;
    run_cmd('{CMD_STATUS}, framed('{RSP_STATUS, 8'h02, 8'h01, ERR_RATE}));
    h_len = 32'h0;
    run_cmd('{CMD_TRANSITION}, '{RSP_ACK});
    chk("op_code", CMD_TRANSITION, op_code);
    chk("boot_state", 2'h2, boot_state);
    run_cmd('{CMD_STATUS}, framed('{RSP_STATUS, 8'h02, 8'h02, ERR_RATE}));
    h_ok = 1'b0;
    h_err = 8'h29;
    run_cmd(framed('{CMD_DEV_SEL, SIZE_DEV_SEL, 8'h41, 8'h42, 8'h43, 8'h46}), '{8'h90, 8'h29});
    chk("dev_code", DEV, dev_code);
    chk("op_code", CMD_DEV_SEL, op_code);
    chk("fwd_seen", 1'b1, fwd_n > 0);
    // Program frame: address plus one unit, no size byte
    h_ok = 1'b1;
    fwd_n = 0;
    exp = '{PROG, 8'h00, 8'h00, 8'h10, 8'h00};
    for (int i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      exp.push_back(rnd[7:0]);
    end
    run_cmd(framed(exp), '{RSP_ACK});
    chk("fwd_count", PROG_ADDR_LEN + 128, fwd_n);
    chk("fwd_data", exp[$], fwd_data);
    rnd = lfsr(rnd);
    pay_q = '{rnd[7:0], rnd[15:8]};
    h_len = 32'h2;
    run_cmd(framed('{MRD, 8'h01, 8'h00}), framed('{MRD + 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, rnd[7:0], rnd[15:8]}));
    complete_run();
  end
endmodule : boot_serial_command_protocol_tb_top
